// file: kpi_pkg.sv
// Package for the pin-change interrupt unit: register map, field positions, resets.
// Assumes a 32-bit APB master; each register takes one aligned word.
package kpi_pkg;
    // ****************************************
    // Register indices and byte address width
    // ****************************************
    localparam logic [7:0] KPI_IDX_STATUS_CONTROL = 8'h0c;
    localparam logic [7:0] KPI_IDX_IRQ_ENABLE = 8'h0d;
    localparam logic [7:0] KPI_IDX_IRQ_POLARITY = 8'h0e;
    localparam logic [7:0] KPI_IDX_EVT_STATUS = 8'h10;
    localparam logic [7:0] KPI_IDX_EVT_CLEAR = 8'h11;
    localparam logic [7:0] KPI_IDX_EVT_ENABLE = 8'h12;
    localparam int KPI_ADDR_W = 12;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int KPI_SC_MODE = 0;
    localparam int KPI_SC_IE = 1;
    localparam int KPI_SC_ACK = 2;
    localparam int KPI_SC_FLAG = 3;
    localparam int KPI_NPINS = 4;
    localparam int KPI_EVT_DETECT = 0;
    localparam int KPI_EVT_ACK_BLOCKED = 1;
    localparam int KPI_NEVT = 2;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] KPI_RST_STATUS_CONTROL = 8'h00;
    localparam logic [3:0] KPI_RST_PIN_ENABLE = 4'h0;
    localparam logic [3:0] KPI_RST_POLARITY = 4'h0;
    localparam logic [1:0] KPI_RST_EVT = 2'h0;

    typedef struct packed {
        logic ie;
        logic mode;
        logic flag;
        logic [3:0] pin_en;
        logic [3:0] pol;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] filt;
        logic [3:0] prev_asserted;
        logic [1:0] evt_status;
        logic [1:0] evt_enable;
        logic [31:0] rdata;
        logic slverr;
    } kpi_state_s;

    function automatic logic [KPI_ADDR_W-1:0] kpi_byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
endpackage

// file: kpi_pin_change_irq_unit.sv
// Pin-change interrupt unit: four pin inputs, flag, acknowledge, APB registers.
// Assumes pins are asynchronous to CLK; pull enable comes from port logic on CLK.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module kpi_pin_change_irq_unit (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [kpi_pkg::KPI_ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Port A pins and pull control
    input wire logic [3:0] PORTA_PINS,
    input wire logic [3:0] PORTA_PULL_ENABLE,
    output logic [3:0] PULLUP_EN,
    output logic [3:0] PULLDOWN_EN,
    // Interrupt
    output logic IRQ
);
    // ****************************************
    // State
    // ****************************************
    kpi_pkg::kpi_state_s state_reg;
    kpi_pkg::kpi_state_s state_next;

    logic setup_phase;
    logic wr_access;
    logic [7:0] wbyte;
    logic [3:0] asserted;
    logic [3:0] edge_hit;
    logic any_level;
    logic set_flag;
    logic ack_req;
    logic ack_ok;
    logic [1:0] evt_set;
    logic [7:0] sc_read;
    logic hit;

    function automatic logic addr_is(input logic [kpi_pkg::KPI_ADDR_W-1:0] a, input logic [7:0] idx);
        return a == kpi_pkg::kpi_byte_addr(idx);
    endfunction

    // ****************************************
    // Detection
    // ****************************************
    always_comb begin
        // Polarity zero asserts low, one asserts high
        asserted = ~(state_reg.filt ^ state_reg.pol);
        // Edge only from deasserted to asserted, filtered view one cycle apart
        edge_hit = state_reg.pin_en & asserted & ~state_reg.prev_asserted;
        any_level = |(state_reg.pin_en & asserted);
        // No halt input: detection never pauses for debug
        set_flag = (|edge_hit) | (state_reg.mode & any_level);
    end

    // ****************************************
    // Bus decode
    // ****************************************
    always_comb begin
        setup_phase = PSEL & ~PENABLE;
        wr_access = PSEL & PENABLE & PWRITE & PSTRB[0];
        wbyte = PWDATA[7:0];
        hit = addr_is(PADDR, kpi_pkg::KPI_IDX_STATUS_CONTROL) | addr_is(PADDR, kpi_pkg::KPI_IDX_IRQ_ENABLE)
            | addr_is(PADDR, kpi_pkg::KPI_IDX_IRQ_POLARITY) | addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_STATUS)
            | addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_CLEAR) | addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_ENABLE);
        ack_req = wr_access & addr_is(PADDR, kpi_pkg::KPI_IDX_STATUS_CONTROL) & wbyte[kpi_pkg::KPI_SC_ACK];
        // Level mode refuses the clear while any enabled input is asserted
        ack_ok = ack_req & ~(state_reg.mode & any_level);
        evt_set = '0;
        evt_set[kpi_pkg::KPI_EVT_DETECT] = set_flag;
        evt_set[kpi_pkg::KPI_EVT_ACK_BLOCKED] = ack_req & ~ack_ok;
        sc_read = '0;
        sc_read[kpi_pkg::KPI_SC_FLAG] = state_reg.flag;
        sc_read[kpi_pkg::KPI_SC_IE] = state_reg.ie;
        sc_read[kpi_pkg::KPI_SC_MODE] = state_reg.mode;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next = state_reg;
        // Three-stage sync; value moves only when stages two and three agree
        state_next.sync1 = PORTA_PINS;
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        state_next.filt = (~(state_reg.sync2 ^ state_reg.sync3) & state_reg.sync3)
            | ((state_reg.sync2 ^ state_reg.sync3) & state_reg.filt);
        state_next.prev_asserted = asserted;
        // Set wins over acknowledge; bit 3 of a status/control write is never looked at
        if (set_flag) begin
            state_next.flag = 1'b1;
        end else if (ack_ok) begin
            state_next.flag = 1'b0;
        end
        if (wr_access) begin
            if (addr_is(PADDR, kpi_pkg::KPI_IDX_STATUS_CONTROL)) begin
                state_next.ie = wbyte[kpi_pkg::KPI_SC_IE];
                state_next.mode = wbyte[kpi_pkg::KPI_SC_MODE];
            end
            if (addr_is(PADDR, kpi_pkg::KPI_IDX_IRQ_ENABLE)) begin
                state_next.pin_en = wbyte[3:0];
            end
            if (addr_is(PADDR, kpi_pkg::KPI_IDX_IRQ_POLARITY)) begin
                state_next.pol = wbyte[3:0];
            end
            if (addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_ENABLE)) begin
                state_next.evt_enable = wbyte[1:0];
            end
        end
        if (wr_access && addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_CLEAR)) begin
            state_next.evt_status = (state_reg.evt_status & ~wbyte[1:0]) | evt_set;
        end else begin
            state_next.evt_status = state_reg.evt_status | evt_set;
        end
        // Read data captured in setup, so access phase never waits
        if (setup_phase) begin
            state_next.slverr = ~hit;
            state_next.rdata = '0;
            if (!PWRITE) begin
                if (addr_is(PADDR, kpi_pkg::KPI_IDX_STATUS_CONTROL)) begin
                    state_next.rdata[7:0] = sc_read;
                end else if (addr_is(PADDR, kpi_pkg::KPI_IDX_IRQ_ENABLE)) begin
                    state_next.rdata[3:0] = state_reg.pin_en;
                end else if (addr_is(PADDR, kpi_pkg::KPI_IDX_IRQ_POLARITY)) begin
                    state_next.rdata[3:0] = state_reg.pol;
                end else if (addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_STATUS)) begin
                    state_next.rdata[1:0] = state_reg.evt_status;
                end else if (addr_is(PADDR, kpi_pkg::KPI_IDX_EVT_ENABLE)) begin
                    state_next.rdata[1:0] = state_reg.evt_enable;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign PRDATA = state_reg.rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & state_reg.slverr;
    assign PULLUP_EN = PORTA_PULL_ENABLE & ~state_reg.pol;
    assign PULLDOWN_EN = PORTA_PULL_ENABLE & state_reg.pol;
    assign IRQ = (state_reg.ie & state_reg.flag) | (|(state_reg.evt_status & state_reg.evt_enable));

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    logic rd_sc_done;
    assign rd_sc_done = PSEL & PENABLE & ~PWRITE & addr_is(PADDR, kpi_pkg::KPI_IDX_STATUS_CONTROL);

    chk_sc_upper_zero: assert property (rd_sc_done |-> PRDATA[7:4] == 4'h0)
        else $error("status/control upper bits not zero");
    chk_ack_reads_zero: assert property (rd_sc_done |-> PRDATA[2] == 1'b0)
        else $error("acknowledge bit read as one");
    chk_flag_write_ignored: assert property (!state_reg.flag && !set_flag |=> !state_reg.flag)
        else $error("flag set without detection");
    chk_irq_request: assert property (state_reg.ie && state_reg.flag |-> IRQ)
        else $error("request missing with enable and flag");
    chk_irq_quiet: assert property (!(state_reg.ie && state_reg.flag)
        && !(|(state_reg.evt_status & state_reg.evt_enable)) |-> !IRQ)
        else $error("request without cause");
    chk_edge_sets_flag: assert property (state_reg.pin_en[0] && asserted[0] && !$past(asserted[0])
        |=> state_reg.flag)
        else $error("edge on enabled pin missed");
    chk_level_sets_flag: assert property (state_reg.mode && any_level |=> state_reg.flag)
        else $error("level did not set flag");
    chk_edge_ack_clears: assert property (!state_reg.mode && ack_req && !set_flag |=> !state_reg.flag)
        else $error("acknowledge did not clear flag");
    chk_level_blocks_ack: assert property (state_reg.flag && state_reg.mode && any_level |=> state_reg.flag)
        else $error("flag cleared while level asserted");
    chk_disabled_silent: assert property (state_reg.pin_en == 4'h0 |-> !set_flag)
        else $error("disabled pins raised detection");
    chk_edge_only_level: assert property (!state_reg.mode && state_reg.flag == 1'b0
        && edge_hit == 4'h0 |=> !state_reg.flag)
        else $error("steady level set flag in edge mode");
    chk_pull_select: assert property ((PULLUP_EN & PULLDOWN_EN) == 4'h0)
        else $error("pullup and pulldown both on");

    cov_edge_flag: cover property (!state_reg.flag ##1 state_reg.flag && !state_reg.mode);
    cov_level_flag: cover property (!state_reg.flag ##1 state_reg.flag && state_reg.mode);
    cov_ack_blocked: cover property (ack_req && !ack_ok);
    cov_irq: cover property (!IRQ ##1 IRQ);
endmodule

// file: kpi_switch_model.sv
// Switch bank on port A: a closed switch drives its level, an open pin follows its pull.
// Assumes the bench sets the switches and the unit drives the pull controls.
`timescale 1ns/1ps
module kpi_switch_model (
    // Clock
    input wire logic clk,
    // Switch settings
    input wire logic [3:0] closed,
    input wire logic [3:0] level,
    // Pull controls
    input wire logic [3:0] pullup_en,
    input wire logic [3:0] pulldown_en,
    // Pins
    output logic [3:0] pins
);
    logic [3:0] float_reg = 4'h0;
    // Unpulled open pins toggle, so a floating value is never trusted
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pins[i] = closed[i] ? level[i] : pullup_en[i] ? 1'b1 : pulldown_en[i] ? 1'b0 : float_reg[i];
        end
    end
endmodule

// file: kpi_pin_change_irq_unit_tb.sv
// Testbench for the pin-change unit: register map, edge and level detection, events.
// Assumes a zero-wait APB slave and the switch model on port A.
`timescale 1ns/1ps
module kpi_pin_change_irq_unit_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] closed = 4'h0;
    logic [3:0] pins;
    logic [3:0] pu;
    logic [3:0] pd;
    logic irq;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    kpi_pin_change_irq_unit dut_u (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PORTA_PINS(pins), .PORTA_PULL_ENABLE(4'hf),
        .PULLUP_EN(pu), .PULLDOWN_EN(pd), .IRQ(irq));
    // Pins 0 and 1 close to ground, pin 2 closes to supply
    kpi_switch_model sw_u (.clk(clk), .closed(closed), .level(4'h4), .pullup_en(pu),
        .pulldown_en(pd), .pins(pins));

    always #12.5 clk = ~clk;
    // Whole run needs well under this
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), exp, rd);
    endtask
    task automatic ic(input logic exp);
        @(posedge clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask
    // Pin path is about five edges deep; eight leaves margin
    task automatic sw(input logic [3:0] c);
        @(posedge clk);
        closed <= c;
        repeat (8) @(posedge clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rc(12'h030, 32'h0);
        rc(12'h034, 32'h0);
        rc(12'h038, 32'h0);
        rc(12'h03c, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("pullup", 32'hf, {28'h0, pu});
        pstrb <= 4'h0;
        apb(1'b1, 12'h038, 32'hff);
        pstrb <= 4'hf;
        rc(12'h038, 32'h00);
        apb(1'b1, 12'h038, 32'hff);
        rc(12'h038, 32'h0f);
        chk("pulldown", 32'hf, {28'h0, pd});
        apb(1'b1, 12'h038, 32'h00);
        $display("t_reset done");
    endtask
    task automatic t_edge;
        apb(1'b1, 12'h030, 32'h00);
        apb(1'b1, 12'h034, 32'h05);
        apb(1'b1, 12'h030, 32'h04);
        apb(1'b1, 12'h030, 32'h02);
        sw(4'h2);
        rc(12'h030, 32'h02);
        sw(4'h3);
        rc(12'h030, 32'h0a);
        ic(1'b1);
        apb(1'b1, 12'h030, 32'hf2);
        rc(12'h030, 32'h0a);
        apb(1'b1, 12'h030, 32'h06);
        rc(12'h030, 32'h02);
        sw(4'h0);
        rc(12'h030, 32'h02);
        $display("t_edge done");
    endtask
    task automatic t_rise;
        apb(1'b1, 12'h038, 32'h04);
        sw(4'h0);
        apb(1'b1, 12'h030, 32'h06);
        rc(12'h030, 32'h02);
        sw(4'h4);
        rc(12'h030, 32'h0a);
        apb(1'b1, 12'h030, 32'h00);
        rc(12'h030, 32'h08);
        ic(1'b0);
        apb(1'b1, 12'h030, 32'h04);
        rc(12'h030, 32'h00);
        sw(4'h0);
        $display("t_rise done");
    endtask
    task automatic t_level;
        apb(1'b1, 12'h044, 32'h03);
        apb(1'b1, 12'h030, 32'h03);
        rc(12'h030, 32'h03);
        sw(4'h1);
        rc(12'h030, 32'h0b);
        apb(1'b1, 12'h030, 32'h07);
        rc(12'h030, 32'h0b);
        sw(4'h2);
        apb(1'b1, 12'h030, 32'h07);
        rc(12'h030, 32'h03);
        rc(12'h040, 32'h03);
        apb(1'b1, 12'h048, 32'h02);
        apb(1'b1, 12'h030, 32'h01);
        ic(1'b1);
        apb(1'b1, 12'h044, 32'h03);
        ic(1'b0);
        rc(12'h040, 32'h00);
        $display("t_level done");
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_edge();
        t_rise();
        t_level();
        results();
    end
endmodule
